/* core/mbw_pkg.sv */
// mbw_pkg: codes, frame layout, timing and states of the register-write slave
// assumes a single 250 MHz clock; used by mbw_crc16 and mbw_slave
package mbw_pkg;

   // ==================================================================
   // protocol codes
   localparam logic [7:0]  FC_READ       = 8'h03;
   localparam logic [7:0]  FC_WR_ONE     = 8'h06;
   localparam logic [7:0]  FC_WR_MULTI   = 8'h10;
   localparam logic [7:0]  EXC_FLAG      = 8'h80;
   localparam logic [7:0]  EXC_NONE      = 8'h00;
   localparam logic [7:0]  EXC_ILL_FUNC  = 8'h01;
   localparam logic [7:0]  EXC_ILL_VALUE = 8'h03;
   localparam logic [7:0]  ADDR_MIN      = 8'h01;
   localparam logic [7:0]  ADDR_MAX      = 8'hf7;
   localparam logic [15:0] MAX_REGS      = 16'h0005;

   // ==================================================================
   // request layout, byte positions from the frame start
   localparam logic [8:0]  POS_ADDR      = 9'h000;
   localparam logic [8:0]  POS_FC        = 9'h001;
   localparam logic [8:0]  POS_AHI       = 9'h002;
   localparam logic [8:0]  POS_ALO       = 9'h003;
   localparam logic [8:0]  POS_BHI       = 9'h004;
   localparam logic [8:0]  POS_BLO       = 9'h005;
   localparam logic [8:0]  POS_BC        = 9'h006;
   localparam logic [8:0]  POS_DATA      = 9'h007;
   localparam logic [8:0]  DATA_BYTES    = 9'h00a;
   localparam logic [8:0]  LEN_WR_ONE    = 9'h008;
   localparam logic [8:0]  LEN_MULTI_HDR = 9'h009;
   localparam logic [8:0]  LEN_MIN       = 9'h004;
   localparam logic [8:0]  IDX_MAX       = 9'h1ff;
   localparam logic [3:0]  LEN_EXC       = 4'h5;
   localparam logic [3:0]  LEN_ECHO      = 4'h8;
   localparam logic [3:0]  CRC_BYTES     = 4'h2;

   // ==================================================================
   // frame check
   localparam logic [15:0] CRC_INIT      = 16'hffff;
   localparam logic [15:0] CRC_POLY      = 16'ha001;
   localparam logic [15:0] CRC_RESIDUE   = 16'h0000;

   // ==================================================================
   // line timing: 9600 bit/s, 8N1 gives ten bit times per character
   localparam longint CLK_HZ     = 250000000;
   localparam longint BAUD_BPS   = 9600;
   localparam longint CHAR_BITS  = 10;
   localparam longint GAP_CHARS  = 3;
   // least time, so rounded up
   localparam longint GAP_CYCLES =
      (CLK_HZ * CHAR_BITS * GAP_CHARS + BAUD_BPS - 1) / BAUD_BPS;

   // ==================================================================
   // controller states
   typedef enum logic [3:0]
   {
      ST_RX    = 4'h1,
      ST_CHECK = 4'h2,
      ST_WRITE = 4'h4,
      ST_SEND  = 4'h8
   } mbw_state_t;

endpackage

/* core/mbw_crc16.sv */
// mbw_crc16: one byte step of the reflected crc-16
// purely combinational; caller holds the running value
`timescale 1ns/1ps
module mbw_crc16
(
   input  wire logic [15:0] crc_in,
   input  wire logic [7:0]  data,
   output logic      [15:0] crc_out
);

   always_comb
   begin
      crc_out = crc_in ^ {8'h00, data};
      for (int i = 0; i < 8; i++)
      begin
         if (crc_out[0])
            crc_out = (crc_out >> 1) ^ mbw_pkg::CRC_POLY;
         else
            crc_out = crc_out >> 1;
      end
   end

endmodule

/* core/mbw_gap_timer.sv */
// mbw_gap_timer: measures line silence since the last received byte
// assumes restart pulses once per byte taken from the receiver
`timescale 1ns/1ps
module mbw_gap_timer
#(
   parameter int unsigned GAP_CYCLES = 781250
)
(
   input  wire logic clk,
   input  wire logic rstn,
   input  wire logic restart,
   output logic      expired
);

   localparam int W = $clog2(GAP_CYCLES + 1);
   localparam logic [W-1:0] LAST = W'(GAP_CYCLES - 1);

   logic [W-1:0] cnt_reg;
   logic [W-1:0] cnt_next;
   logic         done_reg;
   logic         done_next;
   logic         exp_reg;
   logic         exp_next;

   // one pulse per silence; stays quiet until the next byte
   always_comb
   begin
      cnt_next  = cnt_reg;
      done_next = done_reg;
      exp_next  = 1'b0;
      if (restart)
      begin
         cnt_next  = '0;
         done_next = 1'b0;
      end
      else if (!done_reg)
      begin
         if (cnt_reg == LAST)
         begin
            done_next = 1'b1;
            exp_next  = 1'b1;
         end
         else
            cnt_next = cnt_reg + W'(1);
      end
   end

   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         cnt_reg  <= '0;
         done_reg <= 1'b0;
         exp_reg  <= 1'b0;
      end
      else
      begin
         cnt_reg  <= cnt_next;
         done_reg <= done_next;
         exp_reg  <= exp_next;
      end
   end

   assign expired = exp_reg;

endmodule

/* core/mbw_slave.sv */
// mbw_slave: modbus rtu slave engine for the 0x06 and 0x10 register writes
// assumes an external uart for 9600 8N1 bytes and an application that judges
// each register write combinationally through chk_ok
//
// Notes on behaviour
// - request starts with slave address 1..247
// - reply repeats the request's slave address
// - 0x06: address, function, reg, data, crc
// - 0x06 register field picks one destination
// - 0x06 success echoes address and data
// - 0x06 failure answers with function 0x86
// - 0x10: start, count, byte count, data
// - at most five registers per 0x10
// - byte count equals twice the register count
// - words msb first, ascending from start
// - 0x10 success echoes start and count
// - 0x10 failure answers with function 0x90
// - exception: address, function, code, crc
// - exceptions only for valid addressed frames
// - missing or read-only register gives exception
// - crc checked before acting on frame
// - unknown function gives exception 01
// - bad count or value gives exception 03
// - three quiet characters delimit frames
// - fixed 9600 baud 8N1 line
`timescale 1ns/1ps
module mbw_slave
#(
   parameter int unsigned GAP_CYCLES = int'(mbw_pkg::GAP_CYCLES)
)
(
   input  wire logic        clk,
   input  wire logic        rstn,
   input  wire logic [7:0]  slave_addr,
   input  wire logic        rx_valid,
   input  wire logic [7:0]  rx_byte,
   output logic             tx_valid,
   output logic      [7:0]  tx_byte,
   input  wire logic        tx_ready,
   output logic      [15:0] chk_addr,
   output logic      [15:0] chk_data,
   input  wire logic        chk_ok,
   output logic             wr_en,
   output logic      [15:0] wr_addr,
   output logic      [15:0] wr_data
);

   // ==================================================================
   // state
   mbw_pkg::mbw_state_t state_reg, state_next;
   logic [8:0]  idx_reg, idx_next;
   logic        synced_reg, synced_next;
   logic        bad_reg, bad_next;
   logic [15:0] crc_rx_reg, crc_rx_next;
   logic [7:0]  addr_reg, addr_next;
   logic [7:0]  fc_reg, fc_next;
   logic [15:0] a_reg, a_next;
   logic [15:0] b_reg, b_next;
   logic [7:0]  bc_reg, bc_next;
   logic [15:0] word_reg [5];
   logic [15:0] word_next [5];
   logic [2:0]  wi_reg, wi_next;
   logic [2:0]  nw_reg, nw_next;
   logic [7:0]  exc_reg, exc_next;
   logic [3:0]  tk_reg, tk_next;
   logic [3:0]  len_reg, len_next;
   logic [15:0] crc_tx_reg, crc_tx_next;
   logic [7:0]  txb_reg, txb_next;
   logic        txv_reg, txv_next;
   logic        wre_reg, wre_next;
   logic [15:0] wra_reg, wra_next;
   logic [15:0] wrd_reg, wrd_next;

   logic [15:0] crc_rx_upd;
   logic [15:0] crc_tx_upd;
   logic        gap_pulse;
   logic        frame_end;
   logic        len_ok;
   logic        addr_hit;
   logic        frame_good;
   logic [8:0]  widx;
   logic        go_send;

   // ==================================================================
   // helpers
   mbw_crc16 u_crc_rx
   (
      .crc_in  (crc_rx_reg),
      .data    (rx_byte),
      .crc_out (crc_rx_upd)
   );

   mbw_crc16 u_crc_tx
   (
      .crc_in  (crc_tx_reg),
      .data    (txb_reg),
      .crc_out (crc_tx_upd)
   );

   // silence length follows from 9600 baud, 10 bits a character
   mbw_gap_timer #(.GAP_CYCLES(GAP_CYCLES)) u_gap
   (
      .clk     (clk),
      .rstn    (rstn),
      .restart (rx_valid),
      .expired (gap_pulse)
   );

   // payload byte k of the reply; crc bytes are handled by the sender
   function automatic logic [7:0] reply_byte(input logic [3:0] k);
      logic [7:0] v;
      v = addr_reg;
      case (k)
         4'h1: v = (exc_reg != mbw_pkg::EXC_NONE) ?
                   (fc_reg | mbw_pkg::EXC_FLAG) : fc_reg;
         4'h2: v = (exc_reg != mbw_pkg::EXC_NONE) ? exc_reg : a_reg[15:8];
         4'h3: v = a_reg[7:0];
         4'h4: v = b_reg[15:8];
         4'h5: v = b_reg[7:0];
         default: v = addr_reg;
      endcase
      return v;
   endfunction

   // ==================================================================
   // frame judgement
   assign frame_end = (state_reg == mbw_pkg::ST_RX) && gap_pulse
                      && (idx_reg != 9'h000);
   assign widx = idx_reg - mbw_pkg::POS_DATA;
   assign addr_hit = (addr_reg == slave_addr)
                     && (slave_addr >= mbw_pkg::ADDR_MIN)
                     && (slave_addr <= mbw_pkg::ADDR_MAX);

   always_comb
   begin
      case (fc_reg)
         mbw_pkg::FC_WR_ONE:   len_ok = (idx_reg == mbw_pkg::LEN_WR_ONE);
         mbw_pkg::FC_WR_MULTI: len_ok = (idx_reg ==
                               mbw_pkg::LEN_MULTI_HDR + {1'b0, bc_reg});
         default:              len_ok = (idx_reg >= mbw_pkg::LEN_MIN);
      endcase
   end

   // crc over the whole frame including its check leaves zero
   assign frame_good = synced_reg && !bad_reg && len_ok && addr_hit
                       && (crc_rx_reg == mbw_pkg::CRC_RESIDUE);

   // the application judges one word at a time, start address upward
   assign chk_addr = a_reg + {13'h0000, wi_reg};
   assign chk_data = (fc_reg == mbw_pkg::FC_WR_ONE) ? b_reg :
                     word_reg[(wi_reg < 3'h5) ? wi_reg : 3'h0];

   // ==================================================================
   // next state
   always_comb
   begin
      state_next  = state_reg;
      idx_next    = idx_reg;
      synced_next = synced_reg;
      bad_next    = bad_reg;
      crc_rx_next = crc_rx_reg;
      addr_next   = addr_reg;
      fc_next     = fc_reg;
      a_next      = a_reg;
      b_next      = b_reg;
      bc_next     = bc_reg;
      word_next   = word_reg;
      wi_next     = wi_reg;
      nw_next     = nw_reg;
      exc_next    = exc_reg;
      tk_next     = tk_reg;
      len_next    = len_reg;
      crc_tx_next = crc_tx_reg;
      txb_next    = txb_reg;
      txv_next    = txv_reg;
      wre_next    = 1'b0;
      wra_next    = wra_reg;
      wrd_next    = wrd_reg;
      go_send     = 1'b0;

      // a byte that arrives before a full silence poisons its frame
      if (gap_pulse)
         synced_next = 1'b1;
      if (rx_valid && (state_reg != mbw_pkg::ST_RX))
         synced_next = 1'b0;

      case (state_reg)
         mbw_pkg::ST_RX:
         begin
            if (rx_valid)
            begin
               if (idx_reg != mbw_pkg::IDX_MAX)
                  idx_next = idx_reg + 9'h001;
               crc_rx_next = crc_rx_upd;
               if (!synced_reg)
                  bad_next = 1'b1;
               case (idx_reg)
                  mbw_pkg::POS_ADDR: addr_next     = rx_byte;
                  mbw_pkg::POS_FC:   fc_next       = rx_byte;
                  mbw_pkg::POS_AHI:  a_next[15:8]  = rx_byte;
                  mbw_pkg::POS_ALO:  a_next[7:0]   = rx_byte;
                  mbw_pkg::POS_BHI:  b_next[15:8]  = rx_byte;
                  mbw_pkg::POS_BLO:  b_next[7:0]   = rx_byte;
                  mbw_pkg::POS_BC:   bc_next       = rx_byte;
                  default:
                  begin
                     // msb then lsb of each word
                     if ((idx_reg >= mbw_pkg::POS_DATA) && (widx < mbw_pkg::DATA_BYTES))
                     begin
                        if (widx[0])
                           word_next[widx[3:1]][7:0] = rx_byte;
                        else
                           word_next[widx[3:1]][15:8] = rx_byte;
                     end
                  end
               endcase
            end
            else if (frame_end)
            begin
               idx_next    = 9'h000;
               crc_rx_next = mbw_pkg::CRC_INIT;
               bad_next    = 1'b0;
               bc_next     = 8'h00;
               wi_next     = 3'h0;
               // anything failing here is dropped unanswered
               if (frame_good)
               begin
                  case (fc_reg)
                     mbw_pkg::FC_READ: ;  // read requests end here with no reply
                     mbw_pkg::FC_WR_ONE:
                     begin
                        nw_next    = 3'h1;
                        state_next = mbw_pkg::ST_CHECK;
                     end
                     mbw_pkg::FC_WR_MULTI:
                     begin
                        if ((b_reg == 16'h0000) || (b_reg > mbw_pkg::MAX_REGS)
                            || ({8'h00, bc_reg} != {b_reg[14:0], 1'b0}))
                        begin
                           exc_next = mbw_pkg::EXC_ILL_VALUE;
                           go_send  = 1'b1;
                        end
                        else
                        begin
                           nw_next    = b_reg[2:0];
                           state_next = mbw_pkg::ST_CHECK;
                        end
                     end
                     default:
                     begin
                        exc_next = mbw_pkg::EXC_ILL_FUNC;
                        go_send  = 1'b1;
                     end
                  endcase
               end
            end
         end
         mbw_pkg::ST_CHECK:
         begin
            // all words are judged before any is written, so a bad one
            // leaves the whole set untouched
            if (!chk_ok)
            begin
               exc_next = mbw_pkg::EXC_ILL_VALUE;
               go_send  = 1'b1;
            end
            else if (wi_reg == nw_reg - 3'h1)
            begin
               wi_next    = 3'h0;
               state_next = mbw_pkg::ST_WRITE;
            end
            else
               wi_next = wi_reg + 3'h1;
         end
         mbw_pkg::ST_WRITE:
         begin
            wre_next = 1'b1;
            wra_next = chk_addr;
            wrd_next = chk_data;
            if (wi_reg == nw_reg - 3'h1)
            begin
               exc_next = mbw_pkg::EXC_NONE;
               go_send  = 1'b1;
            end
            else
               wi_next = wi_reg + 3'h1;
         end
         mbw_pkg::ST_SEND:
         begin
            if (tx_ready)
            begin
               if (tk_reg == len_reg - 4'h1)
               begin
                  txv_next   = 1'b0;
                  state_next = mbw_pkg::ST_RX;
               end
               else
               begin
                  tk_next = tk_reg + 4'h1;
                  if (tk_reg < len_reg - mbw_pkg::CRC_BYTES)
                     crc_tx_next = crc_tx_upd;
                  // crc low byte first, then high
                  if (tk_next == len_reg - mbw_pkg::CRC_BYTES)
                     txb_next = crc_tx_upd[7:0];
                  else if (tk_next == len_reg - 4'h1)
                     txb_next = crc_tx_reg[15:8];
                  else
                     txb_next = reply_byte(tk_next);
               end
            end
         end
         default:
            state_next = mbw_pkg::ST_RX;
      endcase

      if (go_send)
      begin
         state_next  = mbw_pkg::ST_SEND;
         tk_next     = 4'h0;
         crc_tx_next = mbw_pkg::CRC_INIT;
         txb_next    = addr_reg;
         txv_next    = 1'b1;
         len_next    = (exc_next != mbw_pkg::EXC_NONE) ?
                       mbw_pkg::LEN_EXC : mbw_pkg::LEN_ECHO;
      end
   end

   // ==================================================================
   // registers
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         state_reg  <= mbw_pkg::ST_RX;
         idx_reg    <= 9'h000;
         synced_reg <= 1'b0;
         bad_reg    <= 1'b0;
         crc_rx_reg <= mbw_pkg::CRC_INIT;
         addr_reg   <= 8'h00;
         fc_reg     <= 8'h00;
         a_reg      <= 16'h0000;
         b_reg      <= 16'h0000;
         bc_reg     <= 8'h00;
         for (int i = 0; i < 5; i++)
            word_reg[i] <= 16'h0000;
         wi_reg     <= 3'h0;
         nw_reg     <= 3'h0;
         exc_reg    <= 8'h00;
         tk_reg     <= 4'h0;
         len_reg    <= 4'h0;
         crc_tx_reg <= mbw_pkg::CRC_INIT;
         txb_reg    <= 8'h00;
         txv_reg    <= 1'b0;
         wre_reg    <= 1'b0;
         wra_reg    <= 16'h0000;
         wrd_reg    <= 16'h0000;
      end
      else
      begin
         state_reg  <= state_next;
         idx_reg    <= idx_next;
         synced_reg <= synced_next;
         bad_reg    <= bad_next;
         crc_rx_reg <= crc_rx_next;
         addr_reg   <= addr_next;
         fc_reg     <= fc_next;
         a_reg      <= a_next;
         b_reg      <= b_next;
         bc_reg     <= bc_next;
         word_reg   <= word_next;
         wi_reg     <= wi_next;
         nw_reg     <= nw_next;
         exc_reg    <= exc_next;
         tk_reg     <= tk_next;
         len_reg    <= len_next;
         crc_tx_reg <= crc_tx_next;
         txb_reg    <= txb_next;
         txv_reg    <= txv_next;
         wre_reg    <= wre_next;
         wra_reg    <= wra_next;
         wrd_reg    <= wrd_next;
      end
   end

   assign tx_valid = txv_reg;
   assign tx_byte  = txb_reg;
   assign wr_en    = wre_reg;
   assign wr_addr  = wra_reg;
   assign wr_data  = wrd_reg;

   // ==================================================================
   // checks
   default clocking @(posedge clk); endclocking
   default disable iff (!rstn);

   sequence s_bad_frame;
      frame_end && !frame_good;
   endsequence

   sequence s_ill_func;
      frame_end && frame_good && (fc_reg != mbw_pkg::FC_READ)
      && (fc_reg != mbw_pkg::FC_WR_ONE) && (fc_reg != mbw_pkg::FC_WR_MULTI);
   endsequence

   a_reply_addr_echo: assert property ($rose(tx_valid) |-> tx_byte == slave_addr)
      else $error("reply does not start with own address");
   a_silent_drop: assert property (s_bad_frame |=> (!tx_valid && !wr_en)[*3])
      else $error("rejected frame caused activity");
   // reply bytes advance only with tx_ready, so byte contents are tied to tk_reg
   a_ill_func_code: assert property (s_ill_func |=> tx_valid && exc_reg == 8'h01)
      else $error("unknown function not answered with code 01");
   a_exc_flag_byte: assert property (tx_valid && tk_reg == 4'h1 && exc_reg != 8'h00
      |-> tx_byte == (fc_reg | 8'h80))
      else $error("exception reply lacks flagged function");
   a_exc_code_byte: assert property (tx_valid && tk_reg == 4'h2 && exc_reg != 8'h00
      |-> tx_byte == exc_reg)
      else $error("exception reply lacks its code");
   a_exc_frame_len: assert property ($rose(tx_valid) && exc_reg != 8'h00 |-> len_reg == 4'h5)
      else $error("exception reply length wrong");
   a_write_count_max: assert property (wr_en |-> wr_addr - a_reg < 16'h0005)
      else $error("write beyond five registers");
   // the last check sits two samples before the first write pulse
   a_write_checked: assert property ($rose(wr_en) |->
      $past(state_reg == mbw_pkg::ST_CHECK, 2) && $past(chk_ok, 2))
      else $error("write without passed check");
   a_echo_fc_one: assert property ($rose(tx_valid) && exc_reg == 8'h00 |=> ##[0:20] tx_byte == fc_reg)
      else $error("success reply lacks echoed function");
   a_reject_no_write: assert property (state_reg == mbw_pkg::ST_CHECK && !chk_ok |=> !wr_en [*2] ##1 tx_valid)
      else $error("failed check still wrote");

endmodule

/* tb/mbw_master.sv */
// mbw_master: behavioural modbus master on the byte side of the slave
// assumes the bench calls send() at a falling edge; replies collect in rsp_q
`timescale 1ns/1ps
module mbw_master
#(
   parameter int GAP = 16
)
(
   input  wire logic       clk,
   output logic            rx_valid,
   output logic      [7:0] rx_byte,
   input  wire logic       tx_valid,
   input  wire logic [7:0] tx_byte,
   output logic            tx_ready
);
   logic [7:0] rsp_q[$];

   initial
   begin
      rx_valid = 1'b0;
      rx_byte = 8'h00;
      tx_ready = 1'b0;
   end

   // ==========================================
   // requests: quiet line, then bytes back to back
   task automatic send(input logic [7:0] f[$]);
      repeat (GAP + 4) @(negedge clk);
      foreach (f[i])
      begin
         rx_valid = 1'b1;
         rx_byte = f[i];
         @(negedge clk);
      end
      rx_valid = 1'b0;
      // idle lane must not keep looking like the last byte
      rx_byte = ~rx_byte;
   endtask

   // ==========================================
   // replies, with random stalls
   always @(negedge clk) tx_ready <= 1'($urandom_range(0, 1));
   always @(posedge clk) if (tx_valid && tx_ready) rsp_q.push_back(tx_byte);
endmodule

/* tb/mbw_slave_tb_top.sv */
// mbw_slave_tb_top: frames from the master model, replies and writes checked
// assumes a shortened gap; the application marks page ff read-only, value dead out of range
`timescale 1ns/1ps
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin err_total++; \
   $display("Error t=%0t got %h exp %h", $time, a, b); end end
module mbw_slave_tb_top;
   localparam int GAP = 16;
   logic        clk = 1'b0;
   logic        rstn, rx_valid, tx_valid, tx_ready, chk_ok, wr_en;
   logic [7:0]  sa, rx_byte, tx_byte;
   logic [15:0] chk_addr, chk_data, wr_addr, wr_data;
   logic [7:0]  q[$], exp_q[$];
   logic [31:0] wr_q[$], exp_wr[$];
   logic [7:0]  odd_fc[4] = '{8'h05, 8'h01, 8'h2b, 8'h03};
   int          err_total = 0;
   int          checks_done = 0;

   always #2 clk = ~clk;
   assign chk_ok = (chk_addr[15:8] != 8'hff) && (chk_data != 16'hdead);

   mbw_slave #(.GAP_CYCLES(GAP)) i_mbw_slave (.clk(clk), .rstn(rstn), .slave_addr(sa),
      .rx_valid(rx_valid), .rx_byte(rx_byte), .tx_valid(tx_valid), .tx_byte(tx_byte),
      .tx_ready(tx_ready), .chk_addr(chk_addr), .chk_data(chk_data), .chk_ok(chk_ok),
      .wr_en(wr_en), .wr_addr(wr_addr), .wr_data(wr_data));
   mbw_master #(.GAP(GAP)) i_mbw_master (.clk(clk), .rx_valid(rx_valid),
      .rx_byte(rx_byte), .tx_valid(tx_valid), .tx_byte(tx_byte), .tx_ready(tx_ready));

   always @(posedge clk) if (wr_en) wr_q.push_back({wr_addr, wr_data});

   function automatic logic [15:0] crc16(input logic [7:0] f[$]);
      logic [15:0] c;
      c = 16'hffff;
      foreach (f[i])
      begin
         c ^= {8'h00, f[i]};
         repeat (8) c = c[0] ? ((c >> 1) ^ 16'ha001) : (c >> 1);
      end
      return c;
   endfunction

   task automatic final_report;
      if (err_total == 0 && checks_done > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask

   // ==========================================
   // reference model, one request and its outcome
   task automatic run(input logic [7:0] f[$], input bit bad);
      logic [15:0] c, a, n;
      logic [7:0]  code;
      bit          ok;
      int          k;
      exp_q = {};
      exp_wr = {};
      a = {f[2], f[3]};
      n = {f[4], f[5]};
      code = 8'h00;
      if (f[1] == 8'h06)
      begin
         if (a[15:8] == 8'hff || n == 16'hdead) code = 8'h03;
         else exp_wr.push_back({a, n});
      end
      else if (f[1] == 8'h10)
      begin
         ok = n != 0 && n <= 5 && f[6] == 2 * n && f.size() == 7 + 2 * n;
         for (k = 0; ok && k < n; k++)
            ok = ((a + k) >> 8) != 16'h00ff && {f[7+2*k], f[8+2*k]} != 16'hdead;
         for (k = 0; ok && k < n; k++) exp_wr.push_back({a + 16'(k), f[7+2*k], f[8+2*k]});
         if (!ok) code = 8'h03;
      end
      else if (f[1] != 8'h03) code = 8'h01;
      if (code == 8'h00 && f[1] != 8'h03) for (k = 0; k < 6; k++) exp_q.push_back(f[k]);
      if (code != 8'h00) exp_q = {f[0], f[1] | 8'h80, code};
      if (bad || f[0] != sa || sa == 8'h00 || sa > 8'hf7)
      begin
         exp_q = {};
         exp_wr = {};
      end
      c = crc16(exp_q);
      if (exp_q.size() > 0) exp_q = {exp_q, c[7:0], c[15:8]};
      c = crc16(f);
      f = {f, c[7:0] ^ {7'h00, bad}, c[15:8]};
      wr_q = {};
      i_mbw_master.rsp_q = {};
      i_mbw_master.send(f);
      for (k = 0; k < 400 && (k < GAP + 20 || tx_valid !== 1'b0
           || i_mbw_master.rsp_q.size() < exp_q.size()); k++) @(negedge clk);
      if (k >= 400) err_total++;
      `CHK(i_mbw_master.rsp_q.size(), exp_q.size())
      foreach (exp_q[i]) `CHK(i_mbw_master.rsp_q[i], exp_q[i])
      `CHK(wr_q.size(), exp_wr.size())
      foreach (exp_wr[i]) `CHK(wr_q[i], exp_wr[i])
   endtask

   task automatic multi(input int n, input logic [15:0] a, input int bc);
      q = {sa, 8'h10, a[15:8], a[7:0], 8'h00, 8'(n), 8'(bc)};
      repeat (bc) q.push_back(8'($urandom));
      run(q, 1'b0);
   endtask

   initial
   begin
      void'($urandom(32'h4e15));
      rstn = 1'b0;
      sa = 8'($urandom_range(1, 247));
      repeat (10) @(negedge clk);
      `CHK(tx_valid, 1'b0)
      rstn = 1'b1;
      repeat (3)
      begin
         q = {sa, 8'h06, 8'($urandom_range(0, 254)), 8'($urandom), 8'($urandom), 8'($urandom)};
         run(q, 1'b0);
      end
      q = {sa, 8'h06, 8'hff, 8'h02, 8'h12, 8'h34};
      run(q, 1'b0);
      q = {sa, 8'h06, 8'h00, 8'h11, 8'hde, 8'had};
      run(q, 1'b0);
      for (int n = 0; n <= 6; n++) multi(n, 16'h0120, 2 * n);
      multi(3, 16'hfeff, 6);
      multi(2, 16'h0040, 3);
      foreach (odd_fc[i])
      begin
         q = {sa, odd_fc[i], 8'h00, 8'h10, 8'h00, 8'h01};
         run(q, 1'b0);
      end
      q = {sa, 8'h06, 8'h00, 8'h07, 8'hbe, 8'hef};
      run(q, 1'b1);
      q[0] = sa ^ 8'h01;
      run(q, 1'b0);
      rstn = 1'b0;
      repeat (2) @(negedge clk);
      `CHK(wr_en, 1'b0)
      rstn = 1'b1;
      sa = 8'hf7;
      q = {sa, 8'h06, 8'h00, 8'h07, 8'hbe, 8'hef};
      run(q, 1'b0);
      sa = 8'h00;
      q[0] = sa;
      run(q, 1'b0);
      sa = 8'hf8;
      q[0] = sa;
      run(q, 1'b0);
      final_report;
   end

   initial
   begin
      #200000;
      err_total++;
      final_report;
   end
endmodule
